//--- pkg/rfmc_pkg.sv
// Constants and register layout of the RF front-end mode control block
package rfmc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SEG_W = 8;
  localparam int NUM_REGS = 12;

  // Register offsets
  localparam logic [7:0] OFS_OP_CTRL = 8'h00;
  localparam logic [7:0] OFS_IO_CFG1 = 8'h01;
  localparam logic [7:0] OFS_IO_CFG2 = 8'h02;
  localparam logic [7:0] OFS_AUX_DEF = 8'h03;
  localparam logic [7:0] OFS_NORMAL_LEVEL = 8'h04;
  localparam logic [7:0] OFS_AM_LEVEL = 8'h05;
  localparam logic [7:0] OFS_DEPTH_TARGET = 8'h06;
  localparam logic [7:0] OFS_RX_CFG1 = 8'h07;
  localparam logic [7:0] OFS_RX_CFG2 = 8'h08;
  localparam logic [7:0] OFS_WAKE_PERIOD = 8'h09;
  localparam logic [7:0] OFS_WAKE_REF = 8'h0a;
  localparam logic [7:0] OFS_MASK_TIME = 8'h0b;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_COMMAND = 8'h0d;

  // Operation control fields
  localparam int BIT_OSC_EN = 7;
  localparam int BIT_RX_EN = 6;
  localparam int BIT_RX_CHN = 5;
  localparam int BIT_RX_MAN = 4;
  localparam int BIT_TX_EN = 3;
  localparam int BIT_WAKEUP = 2;
  localparam logic [7:0] WAKE_ONLY = 8'h04;

  // Other fields
  localparam int BIT_SINGLE = 0;
  localparam int BIT_SECOND_OUT = 1;
  localparam int BIT_SLOW_RAMP = 0;
  localparam int BIT_MOD_AM = 0;
  localparam int BIT_OOK_TRI = 1;
  localparam int BIT_AMD_MIXER = 0;
  localparam int BIT_PICK_PM = 1;
  localparam int BIT_DEMOD_BYPASS = 0;
  localparam int BIT_IRQ_OSC = 0;
  localparam int BIT_IRQ_WAKE = 1;
  localparam int BIT_IRQ_CAL = 2;

  // Reset values
  localparam logic [7:0] RST_NORMAL_LEVEL = 8'hff;
  localparam logic [7:0] RST_WAKE_PERIOD = 8'h10;
  localparam logic [7:0] RST_MASK_TIME = 8'h20;

  // Direct commands
  localparam logic [7:0] CMD_CAL_DEPTH = 8'h01;
  localparam logic [7:0] CMD_MASK_RX = 8'h02;
  localparam logic [7:0] CMD_UNMASK_RX = 8'h03;

  // Host-side slow ramp hold time, kept for reference by software
  localparam int SLOW_RAMP_HOLD_US = 2000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLOW_RAMP_HOLD_CYC = (SLOW_RAMP_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [0:0] {
    CAL_IDLE = 1'b0,
    CAL_MEAS = 1'b1
  } rfmc_cal_state_t;
endpackage

//--- core/rfmc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module rfmc_sync (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Data
  input wire logic async_i,
  output logic sync_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } rfmc_sync_state_t;

  rfmc_sync_state_t sync_reg;
  rfmc_sync_state_t sync_next;

  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = async_i;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    // Only accept a level once the last two stages agree
    if (sync_reg.s2 == sync_reg.s3) begin
      sync_next.out = sync_reg.s3;
    end
    if (reset_i) begin
      sync_next = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    sync_reg <= sync_next;
  end

  assign sync_o = sync_reg.out;
endmodule
`default_nettype wire

//--- core/rfmc_timer.sv
// Loadable down-counting timer with a one-cycle expiry pulse
`timescale 1ns/1ps
`default_nettype none
module rfmc_timer (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Control
  input wire logic load_i,
  input wire logic [7:0] value_i,
  input wire logic tick_i,
  // Status
  output logic expired_o,
  output logic running_o
);
  typedef struct packed {
    logic [7:0] cnt;
    logic run;
    logic exp;
  } rfmc_timer_state_t;

  rfmc_timer_state_t tmr_reg;
  rfmc_timer_state_t tmr_next;

  always_comb begin
    tmr_next = tmr_reg;
    tmr_next.exp = 1'b0;
    if (load_i) begin
      tmr_next.cnt = value_i;
      tmr_next.run = 1'b1;
    end else if (tmr_reg.run && tick_i) begin
      // A load of zero expires on the first tick, same as a load of one
      if (tmr_reg.cnt <= 8'h01) begin
        tmr_next.run = 1'b0;
        tmr_next.exp = 1'b1;
        tmr_next.cnt = 8'h00;
      end else begin
        tmr_next.cnt = tmr_reg.cnt - 8'h01;
      end
    end
    if (reset_i) begin
      tmr_next = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    tmr_reg <= tmr_next;
  end

  assign expired_o = tmr_reg.exp;
  assign running_o = tmr_reg.run;
endmodule
`default_nettype wire

//--- core/rfmc_top.sv
// RF front-end operating mode, transmitter and receiver control
//
// Functional notes
// - Power-up clears the operation control register, leaving everything powered down.
// - Register port keeps working in power-down mode.
// - Bit 7 of operation control enables oscillator and regulators: ready mode.
// - Stable oscillator after entering ready mode raises an interrupt.
// - Receiver and transmitter have independent enable bits.
// - Wake-up bit alone selects wake-up mode with periodic timed measurements.
// - In wake-up mode a measurement unlike the reference raises an interrupt.
// - Single-driver bit set: only one antenna driver operates.
// - Each driver has eight segments; normal level register selects them, default all on.
// - In single mode the second-output bit chooses which driver pin is active.
// - Modulation-type bit chooses AM or OOK transmit modulation.
// - OOK stops carrier drive; tristate bit makes drivers high impedance instead.
// - AM modulation reduces the enabled segments during each modulation interval.
// - Calibrate command adjusts the AM level toward the target depth register.
// - Receiver is on exactly when the receiver-enable bit is one.
// - Channel-count bit picks one or both channels; another bit picks auto or manual.
// - Both channels in auto mode: framing logic picks the data channel.
// - Receive window gates receiver processing and opens when mask timer expires.
// - Mask and unmask commands force the receive window low or high.
// - Demodulator-select bit routes AM through peak detector or mixer.
`timescale 1ns/1ps
`default_nettype none
module rfmc_top
  import rfmc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic irq_o,
  // Analog and framing status
  input wire logic osc_amp_ok_i,
  input wire logic rc_osc_tick_i,
  input wire logic meas_done_i,
  input wire logic [7:0] meas_value_i,
  input wire logic mod_active_i,
  input wire logic tx_done_i,
  input wire logic auto_pick_pm_i,
  // Power and receiver control
  output logic osc_enable_o,
  output logic regulator_enable_o,
  output logic wake_mode_o,
  output logic rx_enable_o,
  output logic am_chan_en_o,
  output logic pm_chan_en_o,
  output logic use_pm_chan_o,
  output logic am_demod_mixer_o,
  output logic external_demod_bypass_o,
  output logic slow_ramp_o,
  output logic rx_window_o,
  output logic meas_start_o,
  // Antenna drivers
  output logic [SEG_W-1:0] antenna_drive_a_seg_o,
  output logic antenna_drive_a_oe_o,
  output logic [SEG_W-1:0] antenna_drive_b_seg_o,
  output logic antenna_drive_b_oe_o
);
  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] regs;
    logic [7:0] rdata;
    logic [2:0] irq;
    rfmc_cal_state_t cal_st;
    logic [2:0] cal_bit;
    logic [7:0] cal_trial;
    logic rx_window;
    logic wake_busy, wake_prev, meas_start, rc_prev, osc_prev;
    logic [SEG_W-1:0] seg_a, seg_b;
    logic oe_a, oe_b;
  } rfmc_state_t;

  rfmc_state_t st_reg;
  rfmc_state_t st_next;

  logic osc_ok_sync, rc_tick_sync, wake_exp, mask_exp, wake_load, wake_tick;
  logic tx_on, cal_act, mod, is_am, drv_oe, use_a, use_b;
  logic [SEG_W-1:0] level;

  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction

  function automatic logic [SEG_W-1:0] gate_seg(input logic en, input logic [SEG_W-1:0] lvl);
    gate_seg = en ? lvl : '0;
  endfunction

  rfmc_sync u_sync_osc (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .async_i(osc_amp_ok_i),
    .sync_o(osc_ok_sync)
  );

  rfmc_sync u_sync_rc (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .async_i(rc_osc_tick_i),
    .sync_o(rc_tick_sync)
  );

  // Wake-up interval counts RC oscillator periods, reloaded each expiry
  assign wake_mode_o = (st_reg.regs[OFS_OP_CTRL] == WAKE_ONLY);
  assign wake_tick = wake_mode_o && rc_tick_sync && !st_reg.rc_prev;
  assign wake_load = wake_mode_o && (!st_reg.wake_prev || wake_exp);

  rfmc_timer u_wake_timer (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .load_i(wake_load),
    .value_i(st_reg.regs[OFS_WAKE_PERIOD]),
    .tick_i(wake_tick),
    .expired_o(wake_exp),
    .running_o()
  );

  rfmc_timer u_mask_timer (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .load_i(tx_done_i),
    .value_i(st_reg.regs[OFS_MASK_TIME]),
    .tick_i(1'b1),
    .expired_o(mask_exp),
    .running_o()
  );

  always_comb begin
    logic [7:0] op, aux, io1, kept;
    logic [2:0] irq_set, irq_clr;
    logic keep;
    op = st_reg.regs[OFS_OP_CTRL];
    aux = st_reg.regs[OFS_AUX_DEF];
    io1 = st_reg.regs[OFS_IO_CFG1];
    irq_set = 3'b000;
    irq_clr = 3'b000;
    keep = 1'b0;
    kept = 8'h00;
    st_next = st_reg;
    st_next.meas_start = 1'b0;
    st_next.rc_prev = rc_tick_sync;
    st_next.osc_prev = osc_ok_sync;
    st_next.wake_prev = wake_mode_o;

    // Register port is independent of the power mode
    st_next.rdata = 8'h00;
    if (reg_rd_i) begin
      if (reg_addr_i < OFS_STATUS) begin
        st_next.rdata = st_reg.regs[reg_addr_i[3:0]];
      end else if (reg_addr_i == OFS_STATUS) begin
        st_next.rdata = {st_reg.rx_window, st_reg.cal_st == CAL_MEAS, 3'b000, st_reg.irq};
      end
    end
    if (reg_wr_i) begin
      if (reg_addr_i < OFS_STATUS) begin
        st_next.regs[reg_addr_i[3:0]] = reg_wdata_i;
      end else if (reg_addr_i == OFS_STATUS) begin
        irq_clr = reg_wdata_i[2:0];
      end
    end

    // Ready mode: oscillator settles after enable
    if (op[BIT_OSC_EN] && osc_ok_sync && !st_reg.osc_prev) begin
      irq_set[BIT_IRQ_OSC] = 1'b1;
    end

    // Wake-up presence measurement
    if (wake_exp && wake_mode_o && st_reg.cal_st == CAL_IDLE) begin
      st_next.meas_start = 1'b1;
      st_next.wake_busy = 1'b1;
    end
    if (st_reg.wake_busy && meas_done_i) begin
      st_next.wake_busy = 1'b0;
      if (meas_value_i != st_reg.regs[OFS_WAKE_REF]) begin
        irq_set[BIT_IRQ_WAKE] = 1'b1;
      end
    end
    if (!wake_mode_o) begin
      st_next.wake_busy = 1'b0;
    end

    // Modulation depth calibration by successive approximation
    case (st_reg.cal_st)
      CAL_IDLE: begin
        if (reg_wr_i && reg_addr_i == OFS_COMMAND && reg_wdata_i == CMD_CAL_DEPTH
            && !wake_mode_o && !st_reg.wake_busy) begin
          st_next.cal_st = CAL_MEAS;
          st_next.cal_bit = 3'd7;
          st_next.cal_trial = bit_mask(3'd7);
          st_next.meas_start = 1'b1;
        end
      end
      CAL_MEAS: begin
        if (meas_done_i) begin
          // Keep a segment while the modulated amplitude stays at or under target
          keep = (meas_value_i <= st_reg.regs[OFS_DEPTH_TARGET]);
          kept = keep ? st_reg.cal_trial : (st_reg.cal_trial & ~bit_mask(st_reg.cal_bit));
          if (st_reg.cal_bit == 3'd0) begin
            st_next.regs[OFS_AM_LEVEL] = kept;
            st_next.cal_trial = kept;
            st_next.cal_st = CAL_IDLE;
            irq_set[BIT_IRQ_CAL] = 1'b1;
          end else begin
            st_next.cal_bit = st_reg.cal_bit - 3'd1;
            st_next.cal_trial = kept | bit_mask(st_reg.cal_bit - 3'd1);
            st_next.meas_start = 1'b1;
          end
        end
      end
      default: begin
        st_next.cal_st = CAL_IDLE;
      end
    endcase

    // Receive window: commands override the mask timer in the same cycle
    if (tx_done_i) begin
      st_next.rx_window = 1'b0;
    end else if (mask_exp) begin
      st_next.rx_window = 1'b1;
    end
    if (reg_wr_i && reg_addr_i == OFS_COMMAND) begin
      if (reg_wdata_i == CMD_MASK_RX) begin
        st_next.rx_window = 1'b0;
      end else if (reg_wdata_i == CMD_UNMASK_RX) begin
        st_next.rx_window = 1'b1;
      end
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    st_next.irq = (st_reg.irq & ~irq_clr) | irq_set;

    // Antenna drivers; with AM modulation selected, calibration forces the AM trial level onto the drivers
    tx_on = op[BIT_TX_EN] && op[BIT_OSC_EN];
    cal_act = (st_reg.cal_st == CAL_MEAS);
    mod = mod_active_i || cal_act;
    is_am = aux[BIT_MOD_AM];
    if (!mod) begin
      level = st_reg.regs[OFS_NORMAL_LEVEL];
    end else if (is_am) begin
      level = cal_act ? st_reg.cal_trial : st_reg.regs[OFS_AM_LEVEL];
    end else begin
      level = '0;
    end
    drv_oe = tx_on && !(mod && !is_am && aux[BIT_OOK_TRI]);
    use_a = !io1[BIT_SINGLE] || !io1[BIT_SECOND_OUT];
    use_b = !io1[BIT_SINGLE] || io1[BIT_SECOND_OUT];
    st_next.seg_a = gate_seg(tx_on && use_a, level);
    st_next.seg_b = gate_seg(tx_on && use_b, level);
    st_next.oe_a = drv_oe && use_a;
    st_next.oe_b = drv_oe && use_b;

    if (reset_i) begin
      st_next = '0;
      st_next.regs[OFS_NORMAL_LEVEL] = RST_NORMAL_LEVEL;
      st_next.regs[OFS_WAKE_PERIOD] = RST_WAKE_PERIOD;
      st_next.regs[OFS_MASK_TIME] = RST_MASK_TIME;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    st_reg <= st_next;
  end

  assign reg_rdata_o = st_reg.rdata;
  assign irq_o = |st_reg.irq;
  assign osc_enable_o = st_reg.regs[OFS_OP_CTRL][BIT_OSC_EN];
  assign regulator_enable_o = st_reg.regs[OFS_OP_CTRL][BIT_OSC_EN];
  assign rx_enable_o = st_reg.regs[OFS_OP_CTRL][BIT_RX_EN];
  // Single-channel operation uses the channel named by the manual pick bit
  assign am_chan_en_o = !st_reg.regs[OFS_OP_CTRL][BIT_RX_CHN]
      || !st_reg.regs[OFS_RX_CFG1][BIT_PICK_PM];
  assign pm_chan_en_o = !st_reg.regs[OFS_OP_CTRL][BIT_RX_CHN]
      || st_reg.regs[OFS_RX_CFG1][BIT_PICK_PM];
  assign use_pm_chan_o = (!st_reg.regs[OFS_OP_CTRL][BIT_RX_CHN]
      && !st_reg.regs[OFS_OP_CTRL][BIT_RX_MAN]) ? auto_pick_pm_i
      : st_reg.regs[OFS_RX_CFG1][BIT_PICK_PM];
  assign am_demod_mixer_o = st_reg.regs[OFS_RX_CFG1][BIT_AMD_MIXER];
  assign external_demod_bypass_o = st_reg.regs[OFS_RX_CFG2][BIT_DEMOD_BYPASS];
  assign slow_ramp_o = st_reg.regs[OFS_IO_CFG2][BIT_SLOW_RAMP];
  assign rx_window_o = st_reg.rx_window;
  assign meas_start_o = st_reg.meas_start;
  assign antenna_drive_a_seg_o = st_reg.seg_a;
  assign antenna_drive_a_oe_o = st_reg.oe_a;
  assign antenna_drive_b_seg_o = st_reg.seg_b;
  assign antenna_drive_b_oe_o = st_reg.oe_b;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_op_write(int b);
    reg_wr_i && reg_addr_i == OFS_OP_CTRL && reg_wdata_i[b];
  endsequence
  sequence s_osc_rise;
    osc_enable_o && osc_ok_sync && !st_reg.osc_prev;
  endsequence

  property p_reset_clear;
    disable iff (1'b0) reset_i |=> (st_reg.regs[OFS_OP_CTRL] == 8'h00 && !osc_enable_o
        && !rx_enable_o && !wake_mode_o) ##1 (!antenna_drive_a_oe_o && !antenna_drive_b_oe_o);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("control not cleared at reset");

  property p_readback;
    (reg_rd_i && reg_addr_i == OFS_OP_CTRL) |=> reg_rdata_o == $past(st_reg.regs[OFS_OP_CTRL]);
  endproperty
  a_readback: assert property (p_readback) else $error("operation control readback wrong");

  property p_ready;
    s_op_write(BIT_OSC_EN) |=> osc_enable_o && regulator_enable_o;
  endproperty
  a_ready: assert property (p_ready) else $error("oscillator not enabled by write");

  property p_osc_irq;
    s_osc_rise |=> st_reg.irq[BIT_IRQ_OSC] && irq_o;
  endproperty
  a_osc_irq: assert property (p_osc_irq) else $error("no interrupt on stable oscillator");

  property p_wake_meas;
    (wake_exp && wake_mode_o && st_reg.cal_st == CAL_IDLE) |=> meas_start_o ##1 !meas_start_o;
  endproperty
  a_wake_meas: assert property (p_wake_meas) else $error("wake-up measurement not started");

  property p_wake_irq;
    (st_reg.wake_busy && meas_done_i && meas_value_i != st_reg.regs[OFS_WAKE_REF])
        |=> st_reg.irq[BIT_IRQ_WAKE];
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("no wake-up interrupt on difference");

  property p_single;
    (st_reg.regs[OFS_IO_CFG1][BIT_SINGLE]) [*2] |-> !(antenna_drive_a_oe_o && antenna_drive_b_oe_o);
  endproperty
  a_single: assert property (p_single) else $error("both drivers active in single mode");

  property p_ook_tri;
    (mod_active_i && !st_reg.regs[OFS_AUX_DEF][BIT_MOD_AM] && st_reg.regs[OFS_AUX_DEF][BIT_OOK_TRI])
        |=> !antenna_drive_a_oe_o && !antenna_drive_b_oe_o;
  endproperty
  a_ook_tri: assert property (p_ook_tri) else $error("drivers not tristated in OOK");

  property p_am_level;
    (mod_active_i && st_reg.regs[OFS_AUX_DEF][BIT_MOD_AM] && st_reg.cal_st == CAL_IDLE
        && osc_enable_o && st_reg.regs[OFS_OP_CTRL][BIT_TX_EN] && !st_reg.regs[OFS_IO_CFG1][BIT_SINGLE])
        |=> antenna_drive_a_seg_o == $past(st_reg.regs[OFS_AM_LEVEL]);
  endproperty
  a_am_level: assert property (p_am_level) else $error("AM level not applied");

  property p_mask_open;
    (mask_exp && !tx_done_i && !(reg_wr_i && reg_addr_i == OFS_COMMAND)) |=> rx_window_o;
  endproperty
  a_mask_open: assert property (p_mask_open) else $error("window not opened by mask timer");

  property p_mask_cmd;
    (reg_wr_i && reg_addr_i == OFS_COMMAND && reg_wdata_i == CMD_MASK_RX) |=> !rx_window_o;
  endproperty
  a_mask_cmd: assert property (p_mask_cmd) else $error("mask command did not close window");
endmodule
`default_nettype wire

//--- verif/rfmc_afe_model.sv
// Behavioural analog side: crystal amplitude, RC ticker and measurement unit
`timescale 1ns/1ps
`default_nettype none
module rfmc_afe_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Requests from the block
  input wire logic osc_enable_i,
  input wire logic wake_mode_i,
  input wire logic meas_start_i,
  input wire logic [7:0] drive_level_i,
  // Bench settings
  input wire logic [7:0] presence_i,
  input wire logic [3:0] latency_i,
  // Analog status
  output logic osc_amp_ok_o,
  output logic rc_osc_tick_o,
  output logic meas_done_o,
  output logic [7:0] meas_value_o
);
  logic [5:0] osc_cnt;
  logic [2:0] rc_cnt;
  logic [3:0] busy;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      osc_cnt <= 6'h00;
      rc_cnt <= 3'h0;
      busy <= 4'h0;
      osc_amp_ok_o <= 1'b0;
      rc_osc_tick_o <= 1'b0;
      meas_done_o <= 1'b0;
      meas_value_o <= 8'h00;
    end else begin
      // Amplitude settles a while after enable and collapses at once when disabled
      osc_cnt <= !osc_enable_i ? 6'h00 : (osc_cnt < 6'd20 ? osc_cnt + 6'h01 : osc_cnt);
      osc_amp_ok_o <= osc_cnt == 6'd20;
      rc_cnt <= rc_cnt + 3'h1;
      rc_osc_tick_o <= rc_cnt[2];
      meas_done_o <= busy == 4'h1;
      // Result is only meaningful with done; otherwise the bus keeps toggling
      meas_value_o <= (busy == 4'h1) ? (wake_mode_i ? presence_i : drive_level_i) : ~meas_value_o;
      if (meas_start_i) begin
        busy <= latency_i;
      end else if (busy != 4'h0) begin
        busy <= busy - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the RF front-end mode control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rfmc_pkg::*;
  logic ref_clk_i, reset_i, reg_wr_i, reg_rd_i, mod_active_i, tx_done_i, auto_pick_pm_i;
  logic irq_o, osc_en, reg_en, wake, rx_en, am_ch, pm_ch, use_pm, mixer, bypass, slow, win;
  logic mstart, oe_a, oe_b, osc_ok, rc_tick, mdone;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, mval, seg_a, seg_b, pres, d, tgt;
  logic [3:0] lat;
  logic [7:0] m [0:15];
  int error_cnt = 0;
  int compares = 0;
  int seed = 32'h4a5ab644;
  int n;

  rfmc_top rfmc_top_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .irq_o(irq_o), .osc_amp_ok_i(osc_ok), .rc_osc_tick_i(rc_tick), .meas_done_i(mdone),
    .meas_value_i(mval), .mod_active_i(mod_active_i), .tx_done_i(tx_done_i),
    .auto_pick_pm_i(auto_pick_pm_i), .osc_enable_o(osc_en), .regulator_enable_o(reg_en),
    .wake_mode_o(wake), .rx_enable_o(rx_en), .am_chan_en_o(am_ch), .pm_chan_en_o(pm_ch),
    .use_pm_chan_o(use_pm), .am_demod_mixer_o(mixer), .external_demod_bypass_o(bypass),
    .slow_ramp_o(slow), .rx_window_o(win), .meas_start_o(mstart),
    .antenna_drive_a_seg_o(seg_a), .antenna_drive_a_oe_o(oe_a), .antenna_drive_b_seg_o(seg_b),
    .antenna_drive_b_oe_o(oe_b));

  rfmc_afe_model rfmc_afe_model_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .osc_enable_i(osc_en),
    .wake_mode_i(wake), .meas_start_i(mstart), .drive_level_i(seg_a), .presence_i(pres),
    .latency_i(lat), .osc_amp_ok_o(osc_ok), .rc_osc_tick_o(rc_tick), .meas_done_o(mdone),
    .meas_value_o(mval));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= dt;
    reg_wr_i <= 1'b1;
    if (a < 8'h0c) m[a[3:0]] = dt;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask

  // Bounded wait on irq (sel 0) or the receive window (sel 1)
  task automatic waitfor(input int sel, input int lim);
    n = 0;
    while ((sel == 0 ? irq_o : win) !== 1'b1 && n < lim) begin
      cycles(1);
      n++;
    end
    if ((sel == 0 ? irq_o : win) !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] wait_%0d expected 1 seen timeout", sel);
      tally_and_finish();
    end
  endtask

  function automatic logic [17:0] drv_exp(input logic mod);
    logic [7:0] l;
    logic oe, ea, eb;
    ea = !m[1][0] || !m[1][1];
    eb = !m[1][0] || m[1][1];
    oe = !(mod && !m[3][0] && m[3][1]);
    l = !mod ? m[4] : (m[3][0] ? m[5] : 8'h00);
    if (!(m[0][3] && m[0][7])) return 18'h0;
    return {ea & oe, ea ? l : 8'h00, eb & oe, eb ? l : 8'h00};
  endfunction

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    reset_i = 1'b1;
    {reg_wr_i, reg_rd_i, mod_active_i, tx_done_i, auto_pick_pm_i} = 5'h00;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    pres = 8'h55;
    lat = 4'hc;
    for (int a = 0; a < 16; a++) m[a] = 8'h00;
    m[4] = RST_NORMAL_LEVEL;
    m[9] = RST_WAKE_PERIOD;
    m[11] = RST_MASK_TIME;
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    for (int a = 0; a < 13; a++) begin
      rd(8'(a));
      chk("reset_value", m[a], d);
    end
    chk("powered_down", 5'h00, {osc_en, reg_en, rx_en, oe_a, oe_b});
    wr(8'h30, 8'h5a);
    rd(8'h30);
    chk("unmapped", 8'h00, d);
    wr(OFS_AM_LEVEL, 8'h3c);
    wr(OFS_IO_CFG2, 8'h01);
    rd(OFS_AM_LEVEL);
    chk("pd_access", {1'b1, 8'h3c}, {slow, d});
    wr(OFS_IO_CFG2, 8'h00);
    $display("test reset done");

    wr(OFS_OP_CTRL, 8'h80);
    chk("ready", 2'h3, {osc_en, reg_en});
    waitfor(0, 200);
    rd(OFS_STATUS);
    chk("osc_irq", 8'h01, d & 8'h07);
    wr(OFS_STATUS, 8'h07);
    cycles(1);
    chk("irq_clear", 1'b0, irq_o);
    $display("test ready done");

    // Random modes; slow ramp stays clear so the transmitter is never raced against it
    for (int i = 0; i < 24; i++) begin
      for (int a = 0; a < 9; a++) wr(8'(a), a == 2 ? 8'h00 : 8'($random(seed)));
      @(posedge ref_clk_i);
      mod_active_i <= 1'($random(seed));
      auto_pick_pm_i <= 1'($random(seed));
      cycles(2);
      chk("drive", drv_exp(mod_active_i), {oe_a, seg_a, oe_b, seg_b});
      chk("power", {m[0][7], m[0][7], m[0][6], m[0] == WAKE_ONLY}, {osc_en, reg_en, rx_en, wake});
      chk("chan", {!m[0][5] || !m[7][1], !m[0][5] || m[7][1],
        (!m[0][5] && !m[0][4]) ? auto_pick_pm_i : m[7][1]}, {am_ch, pm_ch, use_pm});
      chk("demod", {m[7][0], m[8][0]}, {mixer, bypass});
    end
    $display("test modes done");

    wr(OFS_OP_CTRL, 8'h00);
    wr(OFS_WAKE_PERIOD, 8'h02);
    wr(OFS_WAKE_REF, 8'h55);
    wr(OFS_STATUS, 8'h07);
    wr(OFS_OP_CTRL, WAKE_ONLY);
    cycles(150);
    rd(OFS_STATUS);
    chk("wake_same", 8'h00, d & 8'h07);
    pres = 8'ha5;
    waitfor(0, 300);
    rd(OFS_STATUS);
    chk("wake_diff", 8'h02, d & 8'h07);
    wr(OFS_OP_CTRL, 8'h00);
    $display("test wake done");

    wr(OFS_MASK_TIME, 8'h05);
    wr(OFS_COMMAND, CMD_UNMASK_RX);
    cycles(1);
    chk("unmask", 1'b1, win);
    wr(OFS_COMMAND, CMD_MASK_RX);
    cycles(1);
    chk("mask", 1'b0, win);
    wr(OFS_COMMAND, CMD_UNMASK_RX);
    @(posedge ref_clk_i);
    tx_done_i <= 1'b1;
    @(posedge ref_clk_i);
    tx_done_i <= 1'b0;
    cycles(3);
    chk("mask_timer", 1'b0, win);
    waitfor(1, 8);
    // Window opens six edges after tx_done is taken; three had passed when the wait began
    chk("window_open", {1'b1, 8'd3}, {win, 8'(n)});
    $display("test window done");

    wr(OFS_OP_CTRL, 8'h88);
    wr(OFS_IO_CFG1, 8'h00);
    // Calibration trims the AM level, so the drivers must run AM modulation
    wr(OFS_AUX_DEF, 8'h01);
    tgt = 8'($random(seed));
    wr(OFS_DEPTH_TARGET, tgt);
    lat = 4'h2;
    cycles(60);
    wr(OFS_STATUS, 8'h07);
    wr(OFS_COMMAND, CMD_CAL_DEPTH);
    waitfor(0, 400);
    rd(OFS_AM_LEVEL);
    chk("cal_level", tgt, d);
    rd(OFS_STATUS);
    chk("cal_done", 8'h04, d & 8'h07);
    $display("test calibration done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
